// ===== core/csi_tx_ctl_pkg.sv
// Shared constants for the transmit port control block.
// Assumes a word-addressed register slave in which each index is one word.
package csi_tx_ctl_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_TX_CTL = 8'h33;
  localparam logic [7:0] IDX_TX_CTL2 = 8'h34;
  localparam logic [7:0] IDX_TX_STATUS = 8'h35;
  localparam logic [7:0] IDX_TX_ENGINE = 8'h38;

  // Fields of transmit_port_control
  localparam int POS_ENABLE = 0;
  localparam int POS_CONT_CLK = 1;
  localparam int POS_LP_LO = 2;
  localparam int POS_LANES_LO = 4;
  localparam int POS_INIT_SKEW = 6;

  // Fields of transmit_port_control_two
  localparam int POS_PERIODIC = 0;
  localparam int POS_ONESHOT = 1;
  localparam int POS_INVERT = 2;
  localparam int POS_PASS_ALL = 3;

  // Reset values and the fixed read value of the upper control-two bits
  localparam logic [7:0] RST_TX_CTL = 8'h00;
  localparam logic [3:0] RST_TX_CTL2 = 4'h0;
  localparam logic [3:0] CTL2_UPPER_READ = 4'h4;

  // Force codes for the low-power field
  localparam logic [1:0] LP_NORMAL = 2'h0;
  localparam logic [1:0] LP_DATA = 2'h1;
  localparam logic [1:0] LP_BOTH = 2'h3;

  // Deskew bytes, sent least significant bit first
  localparam logic [7:0] SKEW_NORMAL = 8'haa;
  localparam logic [7:0] SKEW_INVERT = 8'h55;

  // Default length of one skew-calibration burst, in output words
  localparam int SKEW_WORDS = 16;

endpackage

// ===== core/sync_2ff.sv
// Two-flop synchroniser for a vector of level signals.
// Assumes every bit is a slow level relative to clk.
`timescale 1ns/10ps
module sync_2ff #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Asynchronous side and synchronised side
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } sync_state_t;

  sync_state_t st_reg;
  sync_state_t st_next;

  always_comb begin
    st_next = st_reg;
    st_next.stage1 = async_in;
    st_next.stage2 = st_reg.stage1;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign sync_out = st_reg.stage2;

endmodule

// ===== core/buf_2entry.sv
// Two-entry buffer with valid and ready on both sides.
// Assumes both sides run on clk; storage is flip-flops.
`timescale 1ns/10ps
module buf_2entry #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [PW:0] count;
  } buf_state_t;

  buf_state_t st_reg;
  buf_state_t st_next;
  logic push;
  logic pop;

  // Count is one bit wider than the pointers, so full is compared at its width
  assign in_ready = (st_reg.count != (PW+1)'(DEPTH));
  assign out_valid = (st_reg.count != '0);
  assign out_data = st_reg.mem[st_reg.rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    st_next = st_reg;
    if (push) begin
      st_next.mem[st_reg.wr_ptr] = in_data;
      st_next.wr_ptr = (st_reg.wr_ptr == PW'(DEPTH - 1)) ? '0 :
                       st_reg.wr_ptr + 1'b1;
    end
    if (pop) begin
      st_next.rd_ptr = (st_reg.rd_ptr == PW'(DEPTH - 1)) ? '0 :
                       st_reg.rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      st_next.count = st_reg.count + 1'b1;
    end else if (pop && !push) begin
      st_next.count = st_reg.count - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

endmodule

// ===== core/csi2_transmit_port_control.sv
// Transmit port control: registers, lane control, deskew sequencing, pass.
// Assumes an Avalon-MM master on clk and a link whose clock is sampled.
//
// Functional notes
// - With initial deskew enabled, a calibration burst goes out before data.
// - Lane count codes 00,01,10,11 select four, three, two and one lanes.
// - Force code 01 holds data lanes in LP00, 11 holds data and clock lanes.
// - Continuous clock mode runs the clock lane from the first packet on.
// - Output is produced only while the output enable bit is one.
// - Pass needs any enabled port valid in scope 0, all of them in scope 1.
// - The default calibration pattern alternates starting with a zero bit.
// - The invert bit swaps the calibration pattern to start with a one.
// - Writing one to the one-shot bit sends one burst at the next idle.
// - The one-shot bit clears itself once its burst has been sent.
// - With periodic deskew on, a burst follows every Frame End word.
// - Pass shows live delivery of valid video and drops on a send error.
//
// Register access over Avalon-MM is this design's own decision.
`timescale 1ns/10ps
module csi2_transmit_port_control
  import csi_tx_ctl_pkg::*;
#(
  parameter int DATA_W = 8,
  parameter int SKEW_LEN = SKEW_WORDS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Avalon-MM slave, word addressed
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Incoming video link, sampled on clk
  input wire logic link_clk,
  input wire logic link_valid,
  input wire logic link_frame_end,
  input wire logic [DATA_W-1:0] link_data,
  output logic link_ready,
  // Receive port status, same clock
  input wire logic [1:0] rx_port_enable,
  input wire logic [1:0] rx_video_valid,
  input wire logic tx_error,
  // Lane side towards the PHY
  input wire logic phy_ready,
  output logic [DATA_W-1:0] lane_data,
  output logic lane_valid,
  output logic lane_frame_end,
  output logic lane_deskew,
  output logic [3:0] lane_enable,
  output logic data_lp00,
  output logic clk_lp00,
  output logic clk_lane_run,
  output logic tx_pass
);

  typedef enum logic [1:0] {
    ST_OFF = 2'b00,
    ST_INIT = 2'b01,
    ST_RUN = 2'b10,
    ST_SKEW = 2'b11
  } tx_state_t;

  localparam int CW = $clog2(SKEW_LEN + 1);

  typedef struct packed {
    logic [7:0] ctl;
    logic [3:0] ctl2;
    tx_state_t state;
    logic [CW-1:0] skew_cnt;
    logic skew_is_oneshot;
    logic periodic_due;
    logic seen_packet;
    logic overflow;
    logic link_clk_prev;
    logic link_ready;
    logic [31:0] readdata;
    logic waitrequest;
    logic [DATA_W-1:0] lane_data;
    logic lane_valid;
    logic lane_frame_end;
    logic lane_deskew;
    logic [3:0] lane_enable;
    logic data_lp00;
    logic clk_lp00;
    logic clk_lane_run;
    logic tx_pass;
  } ctl_state_t;

  ctl_state_t st_reg;
  ctl_state_t st_next;

  ////////////////////////////////////////////////////////////////////////////
  // Link sampling and buffering

  logic [DATA_W+2:0] link_sync;
  logic link_clk_s;
  logic link_valid_s;
  logic link_fe_s;
  logic [DATA_W-1:0] link_data_s;
  logic push;
  logic buf_in_ready;
  logic buf_valid;
  logic buf_pop;
  logic [DATA_W:0] buf_word;

  sync_2ff #(
    .WIDTH(DATA_W + 3)
  ) u_link_sync (
    .clk(clk),
    .srst(srst),
    .async_in({link_clk, link_valid, link_frame_end, link_data}),
    .sync_out(link_sync)
  );

  assign link_clk_s = link_sync[DATA_W+2];
  assign link_valid_s = link_sync[DATA_W+1];
  assign link_fe_s = link_sync[DATA_W];
  assign link_data_s = link_sync[DATA_W-1:0];
  // Data settles half a link period before the rising edge
  assign push = link_clk_s && !st_reg.link_clk_prev && link_valid_s;

  buf_2entry #(
    .WIDTH(DATA_W + 1),
    .DEPTH(2)
  ) u_buf (
    .clk(clk),
    .srst(srst),
    .in_valid(push),
    .in_ready(buf_in_ready),
    .in_data({link_fe_s, link_data_s}),
    .out_valid(buf_valid),
    .out_ready(buf_pop),
    .out_data(buf_word)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Decoded controls

  logic out_en;
  logic cont_clk;
  logic [1:0] lp_code;
  logic [1:0] lane_code;
  logic init_skew;
  logic periodic_en;
  logic oneshot;
  logic invert;
  logic pass_all;
  logic [1:0] rx_good;
  logic pass_raw;
  logic force_data;
  logic force_clk;
  logic step;
  logic skew_last;
  logic idle_now;

  assign out_en = st_reg.ctl[POS_ENABLE];
  assign cont_clk = st_reg.ctl[POS_CONT_CLK];
  assign lp_code = st_reg.ctl[POS_LP_LO+:2];
  assign lane_code = st_reg.ctl[POS_LANES_LO+:2];
  assign init_skew = st_reg.ctl[POS_INIT_SKEW];
  assign periodic_en = st_reg.ctl2[POS_PERIODIC];
  assign oneshot = st_reg.ctl2[POS_ONESHOT];
  assign invert = st_reg.ctl2[POS_INVERT];
  assign pass_all = st_reg.ctl2[POS_PASS_ALL];

  // Reserved code 10 behaves as normal operation
  assign force_data = (lp_code == LP_DATA) || (lp_code == LP_BOTH);
  assign force_clk = (lp_code == LP_BOTH);

  assign rx_good = rx_port_enable & rx_video_valid;
  assign pass_raw = pass_all ? ((rx_port_enable != 2'h0) &&
                                (rx_good == rx_port_enable)) :
                               (rx_good != 2'h0);

  // Lanes advance only when the PHY takes a word and LP00 is not forced
  assign step = phy_ready && !force_data && out_en;
  assign skew_last = (st_reg.skew_cnt == CW'(SKEW_LEN - 1));
  assign idle_now = !buf_valid;
  assign buf_pop = (st_reg.state == ST_RUN) && step && buf_valid &&
                   !st_reg.periodic_due;

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  logic req;
  logic wr_hit;
  logic oneshot_done;

  assign req = read || write;
  assign wr_hit = write && !st_reg.waitrequest && byteenable[0];

  always_comb begin
    st_next = st_reg;
    oneshot_done = 1'b0;

    // Bus answer one cycle after the request is seen
    st_next.waitrequest = !(req && st_reg.waitrequest);
    if (req && st_reg.waitrequest) begin
      case (address)
        IDX_TX_CTL: begin
          st_next.readdata = {24'h0, 1'b0, st_reg.ctl[6:0]};
        end
        IDX_TX_CTL2: begin
          st_next.readdata = {24'h0, CTL2_UPPER_READ, st_reg.ctl2};
        end
        IDX_TX_STATUS: begin
          st_next.readdata = {31'h0, st_reg.tx_pass};
        end
        IDX_TX_ENGINE: begin
          st_next.readdata = {28'h0, st_reg.overflow, st_reg.clk_lane_run,
                              (st_reg.state == ST_SKEW),
                              (st_reg.state == ST_RUN)};
        end
        default: begin
          st_next.readdata = 32'h0;
        end
      endcase
    end

    st_next.link_clk_prev = link_clk_s;
    st_next.link_ready = buf_in_ready;

    // Drop marker when the buffer cannot take a sampled word
    if (read && !st_reg.waitrequest && address == IDX_TX_ENGINE) begin
      st_next.overflow = 1'b0;
    end
    if (push && !buf_in_ready) begin
      st_next.overflow = 1'b1;
    end

    // Clear on a PHY accept; forced LP00 withdraws a held word
    if (step || force_data) begin
      st_next.lane_valid = 1'b0;
      st_next.lane_frame_end = 1'b0;
      st_next.lane_deskew = 1'b0;
    end

    case (st_reg.state)
      ST_OFF: begin
        st_next.skew_cnt = '0;
        if (out_en) begin
          if (init_skew) begin
            st_next.state = ST_INIT;
          end else begin
            st_next.state = ST_RUN;
          end
        end
      end
      ST_INIT, ST_SKEW: begin
        if (step) begin
          st_next.lane_valid = 1'b1;
          st_next.lane_deskew = 1'b1;
          st_next.lane_data = invert ? SKEW_INVERT : SKEW_NORMAL;
          st_next.skew_cnt = st_reg.skew_cnt + 1'b1;
          if (skew_last) begin
            st_next.skew_cnt = '0;
            st_next.state = ST_RUN;
            if (st_reg.state == ST_SKEW && st_reg.skew_is_oneshot) begin
              oneshot_done = 1'b1;
            end
          end
        end
      end
      ST_RUN: begin
        if (step) begin
          if (st_reg.periodic_due) begin
            st_next.periodic_due = 1'b0;
            st_next.skew_is_oneshot = 1'b0;
            st_next.state = ST_SKEW;
          end else if (buf_valid) begin
            st_next.lane_valid = 1'b1;
            st_next.lane_data = buf_word[DATA_W-1:0];
            st_next.lane_frame_end = buf_word[DATA_W];
            st_next.seen_packet = 1'b1;
            if (buf_word[DATA_W] && periodic_en) begin
              st_next.periodic_due = 1'b1;
            end
          end else if (oneshot && idle_now) begin
            st_next.skew_is_oneshot = 1'b1;
            st_next.state = ST_SKEW;
          end
        end
      end
      default: begin
        st_next.state = ST_OFF;
      end
    endcase

    if (!out_en) begin
      st_next.state = ST_OFF;
      st_next.lane_valid = 1'b0;
      st_next.lane_frame_end = 1'b0;
      st_next.lane_deskew = 1'b0;
      st_next.periodic_due = 1'b0;
      st_next.seen_packet = 1'b0;
    end

    // Register writes; a fresh one-shot write wins over the self-clear
    if (oneshot_done) begin
      st_next.ctl2[POS_ONESHOT] = 1'b0;
    end
    if (wr_hit && address == IDX_TX_CTL) begin
      st_next.ctl = {1'b0, writedata[6:0]};
    end
    if (wr_hit && address == IDX_TX_CTL2) begin
      st_next.ctl2 = writedata[3:0];
      if (!writedata[POS_ONESHOT] && !oneshot_done) begin
        st_next.ctl2[POS_ONESHOT] = oneshot;
      end
      if (!writedata[POS_ONESHOT] && oneshot_done) begin
        st_next.ctl2[POS_ONESHOT] = 1'b0;
      end
    end

    case (lane_code)
      2'b00: st_next.lane_enable = 4'b1111;
      2'b01: st_next.lane_enable = 4'b0111;
      2'b10: st_next.lane_enable = 4'b0011;
      2'b11: st_next.lane_enable = 4'b0001;
      default: st_next.lane_enable = 4'b0001;
    endcase
    if (!out_en) begin
      st_next.lane_enable = 4'b0000;
    end

    st_next.data_lp00 = force_data || !out_en;
    st_next.clk_lp00 = force_clk || !out_en;
    // Gated clock mode only runs while words are moving
    st_next.clk_lane_run = out_en && !force_clk &&
                           (cont_clk ? st_next.seen_packet :
                            st_next.lane_valid);
    st_next.tx_pass = out_en && pass_raw && !tx_error;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_reg <= '0;
      st_reg.ctl <= RST_TX_CTL;
      st_reg.ctl2 <= RST_TX_CTL2;
      st_reg.state <= ST_OFF;
      st_reg.waitrequest <= 1'b1;
      st_reg.data_lp00 <= 1'b1;
      st_reg.clk_lp00 <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign readdata = st_reg.readdata;
  assign waitrequest = st_reg.waitrequest;
  assign link_ready = st_reg.link_ready;
  assign lane_data = st_reg.lane_data;
  assign lane_valid = st_reg.lane_valid;
  assign lane_frame_end = st_reg.lane_frame_end;
  assign lane_deskew = st_reg.lane_deskew;
  assign lane_enable = st_reg.lane_enable;
  assign data_lp00 = st_reg.data_lp00;
  assign clk_lp00 = st_reg.clk_lp00;
  assign clk_lane_run = st_reg.clk_lane_run;
  assign tx_pass = st_reg.tx_pass;

endmodule

// ===== verification/csi_tx_ctl_sva.sv
// Checker for the transmit port control block.
// Assumes it is bound to the block and sees only its ports.
`timescale 1ns/10ps
module csi_tx_ctl_sva #(
  parameter int DATA_W = 8,
  parameter int SKEW_LEN = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Status and lane side
  input wire logic phy_ready,
  input wire logic [1:0] rx_port_enable,
  input wire logic [1:0] rx_video_valid,
  input wire logic tx_error,
  input wire logic [DATA_W-1:0] lane_data,
  input wire logic lane_valid,
  input wire logic lane_frame_end,
  input wire logic lane_deskew,
  input wire logic [3:0] lane_enable,
  input wire logic data_lp00,
  input wire logic clk_lp00,
  input wire logic tx_pass
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  logic [7:0] run_reg;
  logic [7:0] run_next;
  ////////////////////////////////////////
  // Burst length so far; an accepted skew word adds one, a stall holds it, anything else clears it
  always_comb begin
    run_next = run_reg;
    if (lane_valid && lane_deskew && phy_ready) begin
      run_next = run_reg + 8'h1;
    end else if (!(lane_valid && lane_deskew)) begin
      run_next = 8'h0;
    end
  end
  always_ff @(posedge clk) begin
    run_reg <= srst ? 8'h0 : run_next;
  end
  ////////////////////////////////////////
  a_lane_code:
    assert property (lane_enable inside {4'h0, 4'h1, 4'h3, 4'h7, 4'hf})
    else $error("illegal lane set");
  a_clk_force:
    assert property (clk_lp00 |-> data_lp00)
    else $error("clock forced without data");
  a_lp_silent:
    assert property (data_lp00 && $past(data_lp00) |-> !lane_valid)
    else $error("word sent while forced");
  a_skew_byte:
    assert property (lane_valid && lane_deskew |-> lane_data inside
      {8'haa, 8'h55}) else $error("bad skew byte");
  a_skew_steady:
    assert property (lane_valid && lane_deskew && $past(lane_valid &&
      lane_deskew) |-> $stable(lane_data)) else $error("skew byte moved");
  a_skew_noend:
    assert property (lane_valid && lane_deskew |-> !lane_frame_end)
    else $error("skew word marked frame end");
  a_burst_len:
    assert property (run_reg <= SKEW_LEN)
    else $error("skew burst too long");
  a_pass_error:
    assert property (tx_error |=> !tx_pass)
    else $error("pass kept after error");
  a_pass_cause:
    assert property (tx_pass |-> $past(|(rx_port_enable & rx_video_valid)))
    else $error("pass without valid port");
  c_skew_inv: cover property (lane_valid && lane_deskew && lane_data == 8'h55);
  c_frame_end: cover property (lane_valid && lane_frame_end && phy_ready);
  c_pass: cover property ($rose(tx_pass));
endmodule

bind csi2_transmit_port_control csi_tx_ctl_sva #(.DATA_W(DATA_W),
  .SKEW_LEN(SKEW_LEN)) csi_tx_ctl_sva_inst (.*);

// ===== verification/lane_rx_model.sv
// Lane receiver model: logs every word taken from the lanes.
// Assumes stall 0 is always ready, 1 ready one cycle in four, 2 never.
`timescale 1ns/10ps
module lane_rx_model (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Back-pressure choice
  input wire logic [1:0] stall,
  // Lane side
  input wire logic lane_valid,
  input wire logic lane_frame_end,
  input wire logic lane_deskew,
  input wire logic [7:0] lane_data,
  output logic phy_ready
);
  logic [9:0] seen[$];
  logic [1:0] tick_reg = 2'h0;
  always @(posedge clk) begin
    tick_reg <= srst ? 2'h0 : tick_reg + 2'h1;
    if (!srst && lane_valid && phy_ready) begin
      seen.push_back({lane_frame_end, lane_deskew, lane_data});
    end
  end
  assign phy_ready = stall == 2'h0 || (stall == 2'h1 && tick_reg == 2'h3);
endmodule

// ===== verification/tb_top.sv
// Self-checking bench for the transmit port control block.
// Assumes the lane receiver model and the bound checker are compiled.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin \
  error_cnt++; $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module tb_top
  import csi_tx_ctl_pkg::*;
;
  localparam int SK = 4;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic read = 1'b0;
  logic write = 1'b0;
  logic link_clk = 1'b0;
  logic link_valid = 1'b0;
  logic link_frame_end = 1'b0;
  logic tx_error = 1'b0;
  logic [7:0] address = 8'h00;
  logic [7:0] link_data = 8'h00;
  logic [31:0] writedata = 32'h0;
  logic [3:0] byteenable = 4'h1;
  logic [1:0] rx_port_enable = 2'h0;
  logic [1:0] rx_video_valid = 2'h0;
  logic [1:0] stall = 2'h0;
  logic [31:0] readdata;
  logic [7:0] lane_data;
  logic [7:0] rd;
  logic [3:0] lane_enable;
  logic waitrequest, link_ready, phy_ready, lane_valid, lane_frame_end;
  logic lane_deskew, data_lp00, clk_lp00, clk_lane_run, tx_pass;
  int error_cnt = 0;
  int check_count = 0;
  always #25 clk = ~clk;
  csi2_transmit_port_control #(.DATA_W(8), .SKEW_LEN(SK))
    csi2_transmit_port_control_inst (.*);
  lane_rx_model lane_rx_model_inst (.*);
  ////////////////////////////////////////
  task automatic close_out();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic stuck();
    error_cnt++;
    $display("MISMATCH timeout exp 1 got 0");
    close_out();
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  function automatic logic [9:0] w(input int i);
    return lane_rx_model_inst.seen[i];
  endfunction
  function automatic int nw();
    return lane_rx_model_inst.seen.size();
  endfunction
  task automatic wait_words(input int n);
    int k;
    for (k = 0; k < 2000 && nw() < n; k++) @(posedge clk);
    if (k == 2000) stuck();
  endtask
  // Request holds until the edge that samples waitrequest low
  task automatic bus(input logic wr, input logic [7:0] a,
      input logic [7:0] d);
    int n;
    n = 0;
    address <= a;
    writedata <= {24'h0, d};
    write <= wr;
    read <= !wr;
    @(posedge clk);
    while (waitrequest !== 1'b0) begin
      @(posedge clk);
      n++;
      if (n > 20) stuck();
    end
    rd = readdata[7:0];
    write <= 1'b0;
    read <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e,
      input string nm);
    bus(1'b0, a, 8'h00);
    `CHK(nm, e, rd)
  endtask
  // One link clock period of 8 cycles; data holds 4 cycles each side
  task automatic send(input logic [7:0] d, input logic fe);
    int k;
    for (k = 0; k < 400 && link_ready !== 1'b1; k++) @(posedge clk);
    if (k == 400) stuck();
    link_valid <= 1'b1;
    link_data <= d;
    link_frame_end <= fe;
    cyc(4);
    link_clk <= 1'b1;
    cyc(4);
    link_clk <= 1'b0;
  endtask
  task automatic idle();
    link_valid <= 1'b0;
    link_data <= ~link_data;
    cyc(1);
  endtask
  ////////////////////////////////////////
  task automatic t_regs();
    `CHK("lp_data", 1'b1, data_lp00)
    `CHK("lanes", 4'h0, lane_enable)
    rchk(IDX_TX_CTL, 8'h00, "ctl");
    rchk(IDX_TX_CTL2, 8'h40, "ctl2");
    bus(1'b1, 8'h20, 8'hff);
    rchk(8'h20, 8'h00, "unmapped");
    byteenable <= 4'h0;
    bus(1'b1, IDX_TX_CTL, 8'hff);
    byteenable <= 4'h1;
    rchk(IDX_TX_CTL, 8'h00, "be_off");
    bus(1'b1, IDX_TX_CTL, 8'hff);
    rchk(IDX_TX_CTL, 8'h7f, "ctl_rw");
    // Leave the port off so no burst is pending for later scenarios
    bus(1'b1, IDX_TX_CTL, 8'h00);
    bus(1'b1, IDX_TX_CTL2, 8'h0d);
    rchk(IDX_TX_CTL2, 8'h4d, "ctl2_rw");
    bus(1'b1, IDX_TX_CTL2, 8'h00);
  endtask
  task automatic t_lanes();
    for (int i = 0; i < 4; i++) begin
      // Every lane count code is legal, so all four are stepped through
      bus(1'b1, IDX_TX_CTL, {2'b00, 2'(i), 4'b0001});
      cyc(2);
      `CHK("lane_en", 4'hf >> i, lane_enable)
      bus(1'b1, IDX_TX_CTL, {4'b0000, 2'(i), 2'b01});
      cyc(2);
      `CHK("lp_data", i[0], data_lp00)
      `CHK("lp_clk", i[0] & i[1], clk_lp00)
    end
    bus(1'b1, IDX_TX_CTL, 8'h00);
  endtask
  // Fill while output is off, then drain against a slow receiver
  task automatic t_fill();
    int n;
    n = 0;
    stall <= 2'h1;
    for (int i = 0; i < 5; i++) begin
      if (link_ready === 1'b1) begin
        send(8'h10 + 8'(n), 1'b0);
        idle();
        n++;
      end
      cyc(3);
    end
    `CHK("filled", 2, n)
    `CHK("quiet", 0, nw())
    // A word offered while full is dropped and marks overflow
    link_valid <= 1'b1;
    cyc(4);
    link_clk <= 1'b1;
    cyc(4);
    link_clk <= 1'b0;
    idle();
    cyc(3);
    rchk(IDX_TX_ENGINE, 8'h08, "overflow");
    rchk(IDX_TX_ENGINE, 8'h00, "ovf_clear");
    bus(1'b1, IDX_TX_CTL, 8'h01);
    wait_words(2);
    `CHK("w0", 10'h010, w(0))
    `CHK("w1", 10'h011, w(1))
    bus(1'b1, IDX_TX_CTL, 8'h00);
    lane_rx_model_inst.seen.delete();
  endtask
  task automatic t_init();
    send(8'h21, 1'b0);
    send(8'h22, 1'b0);
    idle();
    cyc(4);
    bus(1'b1, IDX_TX_CTL, 8'h41);
    wait_words(SK + 2);
    for (int k = 0; k < SK; k++) `CHK("skew", 10'h1aa, w(k))
    `CHK("d0", 10'h021, w(SK))
    `CHK("d1", 10'h022, w(SK + 1))
    lane_rx_model_inst.seen.delete();
  endtask
  task automatic t_periodic();
    bus(1'b1, IDX_TX_CTL2, 8'h05);
    send(8'h31, 1'b1);
    send(8'h32, 1'b0);
    idle();
    wait_words(SK + 2);
    `CHK("fe", 10'h231, w(0))
    for (int k = 1; k <= SK; k++) `CHK("inv", 10'h155, w(k))
    `CHK("after", 10'h032, w(SK + 1))
    bus(1'b1, IDX_TX_CTL2, 8'h00);
    lane_rx_model_inst.seen.delete();
  endtask
  task automatic t_oneshot();
    stall <= 2'h2;
    send(8'h41, 1'b0);
    idle();
    cyc(8);
    bus(1'b1, IDX_TX_CTL2, 8'h02);
    rchk(IDX_TX_CTL2, 8'h42, "pending");
    stall <= 2'h1;
    wait_words(SK + 1);
    cyc(40);
    `CHK("count", SK + 1, nw())
    `CHK("first", 10'h041, w(0))
    for (int k = 1; k <= SK; k++) `CHK("one", 10'h1aa, w(k))
    rchk(IDX_TX_CTL2, 8'h40, "cleared");
    lane_rx_model_inst.seen.delete();
  endtask
  task automatic t_pass();
    logic e;
    stall <= 2'h0;
    bus(1'b1, IDX_TX_CTL, 8'h00);
    bus(1'b1, IDX_TX_CTL, 8'h03);
    cyc(3);
    `CHK("run_early", 1'b0, clk_lane_run)
    send(8'h51, 1'b0);
    idle();
    wait_words(1);
    cyc(2);
    `CHK("run", 1'b1, clk_lane_run)
    rchk(IDX_TX_ENGINE, 8'h05, "engine_run");
    rx_port_enable <= 2'h3;
    for (int m = 0; m < 2; m++) begin
      for (int v = 0; v < 4; v++) begin
        rx_video_valid <= 2'(v);
        bus(1'b1, IDX_TX_CTL2, {4'h0, m[0], 3'h0});
        cyc(2);
        e = m[0] ? (v == 3) : (v != 0);
        `CHK("pass", e, tx_pass)
        rchk(IDX_TX_STATUS, {7'h0, e}, "status");
      end
    end
    tx_error <= 1'b1;
    cyc(2);
    `CHK("pass_err", 1'b0, tx_pass)
    tx_error <= 1'b0;
  endtask
  ////////////////////////////////////////
  initial begin
    cyc(20);
    srst <= 1'b0;
    cyc(1);
    t_regs();
    t_lanes();
    t_fill();
    t_init();
    t_periodic();
    t_oneshot();
    t_pass();
    close_out();
  end
endmodule
